/* pkg/e1_sig_defs.vh */
// offsets, field positions, reset values for the signaling/lapd select bank
// assumes: included by bare name, byte address = index * 4 on the bus
`ifndef E1_SIG_DEFS_VH
`define E1_SIG_DEFS_VH

// printed register indexes
`define TX_SIG_CTRL_IDX   12'h340
`define RX_CHAN_CTRL_IDX  12'h360
`define TX_IF_CTRL_IDX    12'h120
`define RX_SDL_SEL_IDX    12'h10C
`define TS_COUNT          32

// tx signaling control fields
`define TSC_ABCD_HI       7
`define TSC_ABCD_LO       4
`define TSC_SRC_HI        1
`define TSC_SRC_LO        0
`define TSC_RESET_TS16    8'hB3
`define TSC_RESET_OTHER   8'hD0
`define TSC_RESET_TS0     8'h01
`define TSC_WR_MASK       8'hF3

// source select encodings
`define SRC_PCM           2'h0
`define SRC_REG           2'h1
`define SRC_PIN           2'h2
`define SRC_XYXX          2'h3

// rx channel control fields
`define RCC_LAPD_HI       7
`define RCC_LAPD_LO       6
`define RCC_RESET         8'h80
`define RCC_WR_MASK       8'hCF
`define LAPD_CTRL1        2'h0
`define LAPD_CTRL2        2'h1
`define LAPD_BY_SDL       2'h2
`define LAPD_CTRL3        2'h3

// tx interface control fields
`define TIC_SIG_IF_BIT    7
`define TIC_MUX_BIT       5
`define TIC_IMODE_HI      4
`define TIC_IMODE_LO      3
`define TIC_WR_MASK       8'hB8
`define TIC_RESET         8'h00

// rx signaling/data-link select fields
`define SDL_DE_HI         1
`define SDL_DE_LO         0
`define SDL_DL_BIT        2
`define SDL_WR_MASK       8'h07
`define SDL_RESET         8'h00

`endif

/* src/e1_signaling_source_and_lapd_select.v */
// per-timeslot tx signaling source and rx lapd routing, ahb-lite slave
// assumes: framer gives timeslot requests on clk; pins are asynchronous
// assumes: host issues single word transfers only
//
// What this block does
// - source 00 takes bits from serial pcm
// - source 01 takes bits from register
// - source 10 base rate uses overhead pin
// - source 10 with interface enable uses signaling pin
// - source 11 inserts none, makes xyxx only
// - reset: ts0 0x01, ts16 0xB3, others 0xD0
// - 32 tx registers from index 0x340
// - lapd field picks controller 1, 2, 3
// - lapd field 10 defers to 0x10C select
// - only controller 1 takes data link bits
// - rx registers 0x360 to 0x37F per timeslot
// - bits 7:4 hold signaling a, b, c, d
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "e1_sig_defs.vh"
module e1_signaling_source_and_lapd_select #(
   parameter [7:0] TS0_RESET = `TSC_RESET_TS0
) (
   input  wire        clk,
   input  wire        rst,
   // ahb-lite slave side
   input  wire        hsel,
   input  wire [13:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // transmit pins, asynchronous to clk
   input  wire        tx_serial_pcm_in,
   input  wire        tx_overhead_in,
   input  wire        tx_signaling_in,
   // framer transmit request and answer
   input  wire        tx_sig_req,
   input  wire [4:0]  tx_ts_index,
   input  wire [1:0]  tx_sig_bit_sel,
   input  wire        tx_alarm_y,
   output reg         tx_sig_valid_q,
   output reg         tx_sig_bit_q,
   output reg         tx_sig_insert_q,
   output reg  [1:0]  tx_sig_src_q,
   output reg         tx_xyxx_valid_q,
   output reg  [3:0]  tx_xyxx_q,
   // framer receive request and answer
   input  wire        rx_de_req,
   input  wire [4:0]  rx_ts_index,
   output reg         rx_de_valid_q,
   output reg  [2:0]  rx_lapd_route_q,
   output reg         rx_dl_lapd1_q,
   output reg  [3:0]  rx_cond_q
);
   // register map, one 8-bit register per aligned word
   //   tx signaling ts0..ts31 : index 0x340..0x35F
   //     [7:4] a b c d (or x y x x), [3:2] zero, [1:0] source
   //   rx channel ts0..ts31   : index 0x360..0x37F
   //     [7:6] lapd select, [5:4] zero, [3:0] conditioning
   //   tx interface control   : index 0x120
   //     [7] signaling-if enable, [5] mux enable, [4:3] mode
   //   rx sig/dl select       : index 0x10C
   //     [2] data link to lapd 1, [1:0] d/e destination
   // upper 24 data bits are ignored on write and read as zero
   // byte addresses from printed indexes
   localparam [13:0] TSC_BASE = {`TX_SIG_CTRL_IDX, 2'b00};
   localparam [13:0] RCC_BASE = {`RX_CHAN_CTRL_IDX, 2'b00};
   localparam [13:0] TIC_ADDR = {`TX_IF_CTRL_IDX, 2'b00};
   localparam [13:0] SDL_ADDR = {`RX_SDL_SEL_IDX, 2'b00};

   wire [7:0] tsc_q [0:`TS_COUNT-1];
   wire [7:0] rcc_q [0:`TS_COUNT-1];
   reg  [7:0] tic_q;
   reg  [7:0] sdl_q;

   // address phase captured for the write data phase
   reg        wr_pend_q;
   reg [13:0] wr_addr_q;
   wire [2:0] pins_sync;

   // pins cross into clk before any selection logic reads them
   // one flop alone would leave metastable values exposed
   // the three pins are independent bits, so one vector is fine
   sync2 #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({tx_signaling_in, tx_overhead_in, tx_serial_pcm_in}),
      .sync_q   (pins_sync)
   );

   // address phase decode
   // only word transfers are taken; others are ignored with okay
   wire        acc_ok  = hsel & hready & htrans[1] & (hsize == 3'h2);
   wire        tsc_hit = (haddr[13:7] == TSC_BASE[13:7]);
   wire        rcc_hit = (haddr[13:7] == RCC_BASE[13:7]);
   wire [4:0]  ts_sel  = haddr[6:2];

   // write strobes for the data phase, by decoded captured address
   // a write lands at the end of the data phase, when hwdata stands
   wire        wr_tsc  = wr_pend_q & (wr_addr_q[13:7] == TSC_BASE[13:7]);
   wire        wr_rcc  = wr_pend_q & (wr_addr_q[13:7] == RCC_BASE[13:7]);
   wire        wr_tic  = wr_pend_q & (wr_addr_q == TIC_ADDR);
   wire        wr_sdl  = wr_pend_q & (wr_addr_q == SDL_ADDR);
   wire [4:0]  wr_ts   = wr_addr_q[6:2];

   // per-timeslot register banks
   // one register pair per timeslot, so a write hits exactly one
   // ts0 default is a parameter; software later writes its zeros
   genvar g;
   generate
      for (g = 0; g < `TS_COUNT; g = g + 1) begin : g_ts
         reg [7:0] tsc_r;
         reg [7:0] rcc_r;
         // reserved bits 3:2 never stored, so they read zero
         always @(posedge clk) begin
            if (rst) begin
               if (g == 0)
                  tsc_r <= TS0_RESET & `TSC_WR_MASK;
               else if (g == 16)
                  tsc_r <= `TSC_RESET_TS16;
               else
                  tsc_r <= `TSC_RESET_OTHER;
            end else if (wr_tsc && wr_ts == g) begin
               tsc_r <= hwdata[7:0] & `TSC_WR_MASK;
            end
         end
         always @(posedge clk) begin
            if (rst)
               rcc_r <= `RCC_RESET;
            else if (wr_rcc && wr_ts == g)
               rcc_r <= hwdata[7:0] & `RCC_WR_MASK;
         end
         assign tsc_q[g] = tsc_r;
         assign rcc_q[g] = rcc_r;
      end
   endgenerate

   // interface control and rx select registers
   // base rate after reset: mux off, mode 00, signaling-if off
   // masks keep unused bits clear so reads show them as zero
   always @(posedge clk) begin
      if (rst) begin
         tic_q <= `TIC_RESET;
         sdl_q <= `SDL_RESET;
      end else begin
         if (wr_tic)
            tic_q <= hwdata[7:0] & `TIC_WR_MASK;
         if (wr_sdl)
            sdl_q <= hwdata[7:0] & `SDL_WR_MASK;
      end
   end

   // read mux; unmapped reads give zero
   // combinational from the address phase, registered into hrdata
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (tsc_hit)
         rd_byte = tsc_q[ts_sel];
      else if (rcc_hit)
         rd_byte = rcc_q[ts_sel];
      else if (haddr == TIC_ADDR)
         rd_byte = tic_q;
      else if (haddr == SDL_ADDR)
         rd_byte = sdl_q;
   end

   // zero wait state slave: read data is ready for the data phase
   // hreadyout never drops: every register answers in one cycle
   // a read right behind a write to the same word sees the old value
   always @(posedge clk) begin
      if (rst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 14'h0000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= acc_ok & hwrite;
         if (acc_ok)
            wr_addr_q <= haddr;
         if (acc_ok && !hwrite)
            hrdata <= {24'h00_0000, rd_byte};
      end
   end

   // tx source decision for the requested timeslot
   // bit select 0 picks a, 3 picks d
   wire [7:0] cur_tsc  = tsc_q[tx_ts_index];
   wire [1:0] cur_src  = cur_tsc[`TSC_SRC_HI:`TSC_SRC_LO];
   wire [3:0] cur_abcd = cur_tsc[`TSC_ABCD_HI:`TSC_ABCD_LO];
   wire       sig_if   = tic_q[`TIC_SIG_IF_BIT];
   wire       base_rt  = ~tic_q[`TIC_MUX_BIT] & ~sig_if &
                         (tic_q[`TIC_IMODE_HI:`TIC_IMODE_LO] == 2'b00);
   wire       reg_bit  = cur_abcd[2'd3 - tx_sig_bit_sel];

   // source 10 outside base rate and without the signaling
   // interface has no pin of its own; it falls back to the
   // serial pcm stream rather than sending stale bits
   // pins arrive two cycles late through the synchroniser,
   // so a pin change just before a request may be missed
   // combinational pick; the flops below register it
   reg        sel_bit;
   reg        sel_ins;
   always @* begin
      sel_bit = pins_sync[0];
      sel_ins = 1'b1;
      case (cur_src)
         `SRC_PCM: sel_bit = pins_sync[0];
         `SRC_REG: sel_bit = reg_bit;
         `SRC_PIN: begin
            if (sig_if)
               sel_bit = pins_sync[2];
            else if (base_rt)
               sel_bit = pins_sync[1];
            else
               sel_bit = pins_sync[0];
         end
         `SRC_XYXX: sel_ins = 1'b0;
         default: sel_ins = 1'b0;
      endcase
   end

   // tx outputs, one cycle after the request
   // data outputs hold until the next request, tx_xyxx_q until the next source 11 request; valid flags pulse
   // x bits come from bits 7, 5, 4; y from the alarm input
   always @(posedge clk) begin
      if (rst) begin
         tx_sig_valid_q  <= 1'b0;
         tx_sig_bit_q    <= 1'b0;
         tx_sig_insert_q <= 1'b0;
         tx_sig_src_q    <= `SRC_PCM;
         tx_xyxx_valid_q <= 1'b0;
         tx_xyxx_q       <= 4'h0;
      end else begin
         tx_sig_valid_q  <= tx_sig_req;
         tx_xyxx_valid_q <= tx_sig_req & (cur_src == `SRC_XYXX);
         if (tx_sig_req) begin
            tx_sig_bit_q    <= sel_bit & sel_ins;
            tx_sig_insert_q <= sel_ins;
            tx_sig_src_q    <= cur_src;
            if (cur_src == `SRC_XYXX)
               tx_xyxx_q <= {cur_abcd[3], tx_alarm_y,
                             cur_abcd[1:0]};
         end
      end
   end

   // rx lapd route for the requested d/e timeslot
   // conditioning bits are only passed on here, not applied
   // one-hot {ctrl3, ctrl2, ctrl1}; 000 means no controller
   wire [7:0] cur_rcc = rcc_q[rx_ts_index];
   wire [1:0] lapd    = cur_rcc[`RCC_LAPD_HI:`RCC_LAPD_LO];
   reg  [2:0] route;
   always @* begin
      route = 3'b000;
      case (lapd)
         `LAPD_CTRL1: route = 3'b001;
         `LAPD_CTRL2: route = 3'b010;
         `LAPD_CTRL3: route = 3'b100;
         `LAPD_BY_SDL: begin
            // 00 in the select register leaves d/e off all controllers
            case (sdl_q[`SDL_DE_HI:`SDL_DE_LO])
               2'h1:    route = 3'b001;
               2'h2:    route = 3'b010;
               2'h3:    route = 3'b100;
               default: route = 3'b000;
            endcase
         end
         default: route = 3'b000;
      endcase
   end

   // rx outputs, one cycle after the request
   // route and conditioning hold until the next request
   // data-link routing is a level, not tied to a request
   always @(posedge clk) begin
      if (rst) begin
         rx_de_valid_q   <= 1'b0;
         rx_lapd_route_q <= 3'b000;
         rx_dl_lapd1_q   <= 1'b0;
         rx_cond_q       <= 4'h0;
      end else begin
         rx_de_valid_q <= rx_de_req;
         // data link never reaches controllers 2 or 3
         rx_dl_lapd1_q <= sdl_q[`SDL_DL_BIT];
         if (rx_de_req) begin
            rx_lapd_route_q <= route;
            rx_cond_q       <= cur_rcc[3:0];
         end
      end
   end
endmodule // e1_signaling_source_and_lapd_select
`default_nettype wire

/* src/sync2.v */
// two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to clk, no reset needed for sampling
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_q
);
   reg [WIDTH-1:0] meta_q;

   // first stage read only by the second
   always @(posedge clk) begin
      if (rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule // sync2
`default_nettype wire

/* tb/ahb_host.sv */
// ahb-lite single-transfer master standing in for the host cpu
// assumes: one slave whose hreadyout comes back as hready
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [13:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   // idle bus at time zero, word transfers only
   initial begin
      hsel = 1'h1;
      haddr = 14'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // address held until hready, then data phase held until hready
   task automatic xfer(input logic w, input logic [13:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata; // read data taken at the closing edge
   endtask
endmodule // ahb_host
`default_nettype wire

/* tb/e1_sig_checker.sv */
// concurrent checks on tx source and rx lapd routing outputs
// assumes: bound to the design top, single clk domain, sync rst
`timescale 1ns/1ps
`default_nettype none
module e1_sig_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       tx_sig_req,
   input wire logic       tx_alarm_y,
   input wire logic       tx_sig_valid_q,
   input wire logic       tx_sig_bit_q,
   input wire logic       tx_sig_insert_q,
   input wire logic [1:0] tx_sig_src_q,
   input wire logic       tx_xyxx_valid_q,
   input wire logic [3:0] tx_xyxx_q,
   input wire logic       rx_de_req,
   input wire logic       rx_de_valid_q,
   input wire logic [2:0] rx_lapd_route_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // answers come one cycle after a request, never unasked
   property p_txv; tx_sig_req |=> tx_sig_valid_q; endproperty
   a_txv: assert property (p_txv) else $error("tx answer late");
   property p_txn; !tx_sig_req |=> !tx_sig_valid_q; endproperty
   a_txn: assert property (p_txn) else $error("tx answer unasked");
   // source 11 inserts nothing and raises xyxx
   property p_x11; tx_sig_valid_q && tx_sig_src_q == 2'h3
      |-> !tx_sig_insert_q && !tx_sig_bit_q && tx_xyxx_valid_q; endproperty
   a_x11: assert property (p_x11) else $error("xyxx mode wrong");
   property p_ins; tx_sig_valid_q && tx_sig_src_q != 2'h3
      |-> tx_sig_insert_q && !tx_xyxx_valid_q; endproperty
   a_ins: assert property (p_ins) else $error("insert flag wrong");
   // y bit follows the alarm seen with the request
   property p_y; tx_xyxx_valid_q |-> tx_xyxx_q[2] == $past(tx_alarm_y);
   endproperty
   a_y: assert property (p_y) else $error("y bit wrong");
   property p_xv; tx_xyxx_valid_q |-> tx_sig_valid_q; endproperty
   a_xv: assert property (p_xv) else $error("xyxx without valid");
   property p_rxv; rx_de_req |=> rx_de_valid_q; endproperty
   a_rxv: assert property (p_rxv) else $error("rx answer late");
   // never two controllers on one timeslot
   property p_hot; rx_de_valid_q |-> $onehot0(rx_lapd_route_q); endproperty
   a_hot: assert property (p_hot) else $error("route not one-hot");
endmodule // e1_sig_checker
bind e1_signaling_source_and_lapd_select e1_sig_checker chk_i (
   .clk(clk), .rst(rst), .tx_sig_req(tx_sig_req),
   .tx_alarm_y(tx_alarm_y), .tx_sig_valid_q(tx_sig_valid_q),
   .tx_sig_bit_q(tx_sig_bit_q), .tx_sig_insert_q(tx_sig_insert_q),
   .tx_sig_src_q(tx_sig_src_q), .tx_xyxx_valid_q(tx_xyxx_valid_q),
   .tx_xyxx_q(tx_xyxx_q), .rx_de_req(rx_de_req),
   .rx_de_valid_q(rx_de_valid_q), .rx_lapd_route_q(rx_lapd_route_q));
`default_nettype wire

/* tb/e1_signaling_source_and_lapd_select_tb_top.sv */
// register and datapath tests for the signaling/lapd select block
// assumes: ahb_host drives the bus, pins change long before requests
`timescale 1ns/1ps
`default_nettype none
module e1_signaling_source_and_lapd_select_tb_top;
   logic clk = 1'b0, rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp;
   logic [13:0] haddr;
   logic [1:0] htrans, tx_sig_bit_sel = 2'h0, tx_sig_src_q;
   logic [2:0] hsize, rx_lapd_route_q;
   logic [31:0] hwdata, hrdata, q;
   logic tx_serial_pcm_in = 1'b0, tx_overhead_in = 1'b1;
   logic tx_signaling_in = 1'b0, tx_alarm_y = 1'b1;
   logic tx_sig_req = 1'b0, rx_de_req = 1'b0;
   logic [4:0] tx_ts_index = 5'h0, rx_ts_index = 5'h0;
   logic tx_sig_valid_q, tx_sig_bit_q, tx_sig_insert_q, tx_xyxx_valid_q;
   logic rx_de_valid_q, rx_dl_lapd1_q;
   logic [3:0] tx_xyxx_q, rx_cond_q;
   int num_errors = 0, n_compared = 0;
   int ex[4] = '{1, 2, 1, 4};

   always #5 clk = ~clk;

   ahb_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   e1_signaling_source_and_lapd_select dut (.clk(clk), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tx_serial_pcm_in(tx_serial_pcm_in), .tx_overhead_in(tx_overhead_in),
      .tx_signaling_in(tx_signaling_in), .tx_sig_req(tx_sig_req),
      .tx_ts_index(tx_ts_index), .tx_sig_bit_sel(tx_sig_bit_sel),
      .tx_alarm_y(tx_alarm_y), .tx_sig_valid_q(tx_sig_valid_q),
      .tx_sig_bit_q(tx_sig_bit_q), .tx_sig_insert_q(tx_sig_insert_q),
      .tx_sig_src_q(tx_sig_src_q), .tx_xyxx_valid_q(tx_xyxx_valid_q),
      .tx_xyxx_q(tx_xyxx_q), .rx_de_req(rx_de_req),
      .rx_ts_index(rx_ts_index), .rx_de_valid_q(rx_de_valid_q),
      .rx_lapd_route_q(rx_lapd_route_q), .rx_dl_lapd1_q(rx_dl_lapd1_q),
      .rx_cond_q(rx_cond_q));

   task automatic chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // one request pulse; bit select follows the timeslot's low bits
   task automatic pulse(input logic rx, input logic [4:0] t);
      @(posedge clk);
      tx_sig_req <= !rx;
      rx_de_req <= rx;
      tx_ts_index <= t;
      rx_ts_index <= t;
      tx_sig_bit_sel <= t[1:0];
      @(posedge clk);
      tx_sig_req <= 1'b0;
      rx_de_req <= 1'b0;
      #1;
   endtask

   task automatic close_out;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog far beyond the roughly 300 cycles of the tests
   initial begin
      #100000;
      num_errors++;
      close_out;
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < 32; n++) begin
         host.xfer(1'b0, 14'(14'hD00 + 4 * n), 32'h0, q);
         chk("tx reset", n == 0 ? 1 : n == 16 ? 32'hB3 : 32'hD0, q);
         host.xfer(1'b0, 14'(14'hD80 + 4 * n), 32'h0, q);
         chk("rx reset", 32'h80, q);
      end
      host.xfer(1'b1, 14'h3FFC, 32'hFF, q);
      host.xfer(1'b0, 14'h3FFC, 32'h0, q);
      chk("unmapped", 32'h0, q);
      chk("ready resp", 32'h2, {hreadyout, hresp});
      host.xfer(1'b1, 14'hD00, 32'h01, q);
      $display("test reset values done");
      // ts5 holds abcd 0101; pcm 0, overhead 1 tell the sources apart
      for (int s = 0; s < 4; s++) begin
         host.xfer(1'b1, 14'hD14, 32'h5C | s, q);
         host.xfer(1'b0, 14'hD14, 32'h0, q);
         chk("tx reg", 32'h50 | s, q);
         pulse(1'b0, 5'h5);
         chk("src", s, tx_sig_src_q);
         chk("bit", s == 1 || s == 2, tx_sig_bit_q);
         chk("ins", s != 3, tx_sig_insert_q);
      end
      chk("xyxx", 32'h5, tx_xyxx_q);
      // signaling pin high, the other two low, for the interface case
      @(posedge clk);
      tx_overhead_in <= 1'b0;
      tx_signaling_in <= 1'b1;
      host.xfer(1'b1, 14'h480, 32'h80, q);
      host.xfer(1'b1, 14'hD14, 32'h52, q);
      pulse(1'b0, 5'h5);
      chk("sig pin", 32'h1, tx_sig_bit_q);
      // mux enable leaves base rate: back to pcm, not the pins
      @(posedge clk);
      tx_overhead_in <= 1'b1;
      host.xfer(1'b1, 14'h480, 32'h20, q);
      pulse(1'b0, 5'h5);
      chk("no base", 32'h0, tx_sig_bit_q);
      $display("test tx sources done");
      host.xfer(1'b1, 14'h430, 32'h05, q);
      for (int l = 0; l < 4; l++) begin
         host.xfer(1'b1, 14'hD8C, {l[1:0], 6'h9}, q);
         pulse(1'b1, 5'h3);
         chk("route", ex[l], rx_lapd_route_q);
         chk("cond", 32'h9, rx_cond_q);
      end
      chk("dl", 32'h1, rx_dl_lapd1_q);
      // select register 00 parks d/e away from every controller
      host.xfer(1'b1, 14'h430, 32'h00, q);
      host.xfer(1'b1, 14'hD8C, 32'h89, q);
      pulse(1'b1, 5'h3);
      chk("route off", 32'h0, rx_lapd_route_q);
      chk("dl off", 32'h0, rx_dl_lapd1_q);
      $display("test rx routing done");
      close_out;
   end
endmodule // e1_signaling_source_and_lapd_select_tb_top
`default_nettype wire
